// *** inc/flash_ctl_defs.vh ***
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH
`define ADR_CTL0       4'h0
`define ADR_CTL1       4'h4
`define ADR_WIDTH      4
`define B_READY        0
`define B_REWRITE      1
`define B_LOCK_OVR     2
`define B_STOP         3
`define B_AREA         5
`define B_PERR         6
`define B_EERR         7
`define B_INPLACE      1
`define B_LOCK_RES     6
`define CTL0_RESET     8'h01
`define CTL1_RESET     8'h00
`define OP_IDLE        3'd0
`define OP_PROGRAM     3'd1
`define OP_ERASE       3'd2
`define OP_LOCK_PROG   3'd3
`define OP_LOCK_READ   3'd4
`define OP_CLEAR       3'd5
`endif

// *** hw/set_guard.v ***
`timescale 1ns/100ps
`include "flash_ctl_defs.vh"
// Guarded bit: a 1 write sticks only if the last write to the bit was 0.
module set_guard (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire clk_en,
  input  wire wr,
  input  wire wdata,
  input  wire allow,
  input  wire clr,
  output reg  q
);
  reg armed;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q     <= 1'b0;
      armed <= 1'b0;
    end else if (clk_en) begin
      if (clr) begin
        q     <= 1'b0;
        armed <= 1'b0;
      end else if (wr) begin
        armed <= ~wdata;
        if (!wdata)
          q <= 1'b0;
        else if (armed && allow)
          q <= 1'b1;
      end
    end
  end
endmodule // set_guard

// *** hw/flash_rewrite_mode_control.v ***
`timescale 1ns/100ps
`include "flash_ctl_defs.vh"
module flash_rewrite_mode_control #(
  parameter BLOCKS = 11
) (
  input  wire                  clk_sys,
  input  wire                  rst_n,
  input  wire                  clk_en,
  input  wire                  wb_cyc_i,
  input  wire                  wb_stb_i,
  input  wire                  wb_we_i,
  input  wire [`ADR_WIDTH-1:0] wb_adr_i,
  input  wire [31:0]           wb_dat_i,
  input  wire [3:0]            wb_sel_i,
  output reg  [31:0]           wb_dat_o,
  output reg                   wb_ack_o,
  input  wire                  nmi_event,
  input  wire                  wdt_event,
  input  wire                  boot_mode,
  input  wire [2:0]            op_start,
  input  wire [3:0]            op_block,
  input  wire                  op_done,
  input  wire                  op_fail,
  input  wire                  op_lock_state,
  output reg                   cmd_accept,
  output reg                   inplace_submode,
  output reg                   status_reg_readable,
  output reg                   lock_ignore,
  output reg  [BLOCKS-1:0]     block_unlocked,
  output reg                   flash_access_ok,
  output reg                   flash_low_power,
  output reg                   flash_init,
  output reg                   map_user_area,
  output reg                   op_abort
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  reg        state;
  reg [2:0]  cur_op;
  reg [3:0]  cur_block;
  reg        lock_override_bit;
  reg        flash_stop_bit;
  reg        boot_area_select_bit;
  reg        program_error_flag;
  reg        erase_error_flag;
  reg        lock_result_bit;
  wire       rewrite_enable_bit;
  wire       inplace_submode_bit;
  reg        next_state;

  wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr0    = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ADR_CTL0);
  wire wr1    = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ADR_CTL1);
  wire reinit = nmi_event | wdt_event;
  wire flash_ready_flag = (state == ST_IDLE);

  // Clearing rewrite-enable also drops the sub-mode bit.
  wire clr_submode = reinit | (wr0 & ~wb_dat_i[`B_REWRITE]);

  set_guard u_rewrite (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr      (wr0),
    .wdata   (wb_dat_i[`B_REWRITE]),
    .allow   (1'b1),
    .clr     (reinit),
    .q       (rewrite_enable_bit)
  );

  set_guard u_inplace (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr      (wr1),
    .wdata   (wb_dat_i[`B_INPLACE]),
    .allow   (rewrite_enable_bit),
    .clr     (clr_submode),
    .q       (inplace_submode_bit)
  );

  // Lock-override is guarded the same way but has no prerequisite.
  reg lock_ovr_armed;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (op_start != `OP_IDLE && op_start != `OP_CLEAR && rewrite_enable_bit
            && !(flash_stop_bit))
          next_state = ST_BUSY;
      end
      ST_BUSY: begin
        if (op_done || reinit || flash_stop_bit)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // A clear-status command only counts while rewrite is enabled.
  wire clear_cmd = (op_start == `OP_CLEAR) & rewrite_enable_bit;
  wire finish    = (state == ST_BUSY) & op_done;

  // Operation tracker: remembers the kind and block of the running operation.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cur_op    <= `OP_IDLE;
      cur_block <= 4'h0;
    end else if (clk_en) begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_BUSY) begin
        cur_op    <= op_start;
        cur_block <= op_block;
      end
    end
  end

  // The answer comes one cycle after the request; a held request sees gaps.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else if (clk_en)
      wb_ack_o <= req;
  end

  // Abort pulse tells the array to drop a running operation.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      op_abort <= 1'b0;
    else if (clk_en)
      op_abort <= (state == ST_BUSY) & (reinit | flash_stop_bit);
  end

  // Lock-override is guarded like rewrite-enable, but needs no prerequisite.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_override_bit <= 1'b0;
      lock_ovr_armed    <= 1'b0;
    end else if (clk_en) begin
      if (reinit) begin
        lock_override_bit <= 1'b0;
        lock_ovr_armed    <= 1'b0;
      end else if (wr0) begin
        lock_ovr_armed <= ~wb_dat_i[`B_LOCK_OVR];
        if (!wb_dat_i[`B_LOCK_OVR])
          lock_override_bit <= 1'b0;
        else if (lock_ovr_armed)
          lock_override_bit <= 1'b1;
      end
    end
  end

  // The stop bit is a plain write; besides aborting a busy operation, it only reaches the array while rewrite is on.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      flash_stop_bit <= 1'b0;
    else if (clk_en) begin
      if (reinit)
        flash_stop_bit <= 1'b0;
      else if (wr0)
        flash_stop_bit <= wb_dat_i[`B_STOP];
    end
  end

  // Area select is a plain write, cleared by reinit with the rest of the register.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      boot_area_select_bit <= 1'b0;
    else if (clk_en) begin
      if (reinit)
        boot_area_select_bit <= 1'b0;
      else if (wr0)
        boot_area_select_bit <= wb_dat_i[`B_AREA];
    end
  end

  // Software cannot write the error flags; clear-status wins over a finishing op.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      program_error_flag <= 1'b0;
    else if (clk_en) begin
      if (reinit)
        program_error_flag <= 1'b0;
      else if (clear_cmd)
        program_error_flag <= 1'b0;
      else if (finish && cur_op == `OP_PROGRAM && op_fail)
        program_error_flag <= 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      erase_error_flag <= 1'b0;
    else if (clk_en) begin
      if (reinit)
        erase_error_flag <= 1'b0;
      else if (clear_cmd)
        erase_error_flag <= 1'b0;
      else if (finish && cur_op == `OP_ERASE && op_fail)
        erase_error_flag <= 1'b1;
    end
  end

  // The lock result keeps the answer of the last lock-status read until reinit.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      lock_result_bit <= 1'b0;
    else if (clk_en) begin
      if (reinit)
        lock_result_bit <= 1'b0;
      else if (!clear_cmd && finish && cur_op == `OP_LOCK_READ)
        lock_result_bit <= op_lock_state;
    end
  end

  // Read data is captured with the request and stands until the next read.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (clk_en && req && !wb_we_i) begin
      case (wb_adr_i)
        `ADR_CTL0:
          wb_dat_o <= {24'h00_0000, erase_error_flag, program_error_flag,
                       boot_area_select_bit, 1'b0, flash_stop_bit,
                       lock_override_bit, rewrite_enable_bit,
                       flash_ready_flag};
        `ADR_CTL1:
          wb_dat_o <= {24'h00_0000, 1'b0, lock_result_bit, 4'h0,
                       inplace_submode_bit, 1'b0};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Stored lock data survives override; only erase or lock program change it.
  // A block index beyond the table matches no entry, so it changes nothing.
  wire [BLOCKS-1:0] next_unlocked;
  genvar gi;
  generate
    for (gi = 0; gi < BLOCKS; gi = gi + 1) begin : g_lock
      localparam [3:0] IDX = gi;
      wire hit = finish & ~reinit & ~op_fail & (cur_block == IDX);
      assign next_unlocked[gi] =
        (hit & (cur_op == `OP_ERASE) & lock_override_bit) ? 1'b1 :
        (hit & (cur_op == `OP_LOCK_PROG))                 ? 1'b0 :
                                                            block_unlocked[gi];
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      block_unlocked <= {BLOCKS{1'b0}};
    else if (clk_en)
      block_unlocked <= next_unlocked;
  end

  // Flash-facing controls, each registered so every output comes from a flop.
  // They lag the register bits by one cycle, which software never sees.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      cmd_accept <= 1'b0;
    else if (clk_en)
      cmd_accept <= rewrite_enable_bit & ~flash_stop_bit;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      inplace_submode <= 1'b0;
    else if (clk_en)
      inplace_submode <= rewrite_enable_bit & inplace_submode_bit;
  end

  // The status register is hidden whenever code runs in place.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      status_reg_readable <= 1'b0;
    else if (clk_en)
      status_reg_readable <= rewrite_enable_bit & ~inplace_submode_bit;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      lock_ignore <= 1'b0;
    else if (clk_en)
      lock_ignore <= lock_override_bit;
  end

  // Stop without rewrite-enable leaves the array awake and reachable.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      flash_access_ok <= 1'b1;
    else if (clk_en)
      flash_access_ok <= ~(flash_stop_bit & rewrite_enable_bit);
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      flash_low_power <= 1'b0;
    else if (clk_en)
      flash_low_power <= flash_stop_bit & rewrite_enable_bit;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      flash_init <= 1'b0;
    else if (clk_en)
      flash_init <= (flash_stop_bit & rewrite_enable_bit) | reinit;
  end

  // Outside boot mode the user area is always the one mapped.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      map_user_area <= 1'b0;
    else if (clk_en)
      map_user_area <= ~boot_mode | boot_area_select_bit;
  end
endmodule // flash_rewrite_mode_control

// *** dv/flash_rewrite_mode_control_props.sv ***
`timescale 1ns/100ps
`include "flash_ctl_defs.vh"
module flash_rewrite_mode_control_props #(parameter BLOCKS = 11) (
  input wire logic                  clk_sys, rst_n, clk_en, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic [`ADR_WIDTH-1:0] wb_adr_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic                  wb_ack_o, nmi_event, wdt_event, boot_mode, op_done, op_fail,
  input wire logic                  inplace_submode, status_reg_readable, lock_ignore,
  input wire logic [BLOCKS-1:0]     block_unlocked,
  input wire logic                  flash_access_ok, flash_low_power, map_user_area
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  wire off0 = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADR_CTL0 && !wb_dat_i[`B_REWRITE];
  chk_ack_latency: assert property (take |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_submode_drop: assert property (off0 |-> ##[1:2] !inplace_submode)
    else $error("in-place kept after rewrite off");
  chk_status_hidden: assert property (inplace_submode |-> !status_reg_readable)
    else $error("status readable in place");
  chk_reinit_clears: assert property ((nmi_event || wdt_event) && clk_en |->
    ##[1:2] (!inplace_submode && !lock_ignore)) else $error("no reinit");
  chk_stop_blocks: assert property (flash_low_power |-> !flash_access_ok)
    else $error("access while stopped");
  chk_lock_data_kept: assert property ((lock_ignore != $past(lock_ignore)) &&
    !$past(op_done) && !$past(op_done, 2) |-> $stable(block_unlocked)) else $error("lock data moved");
  chk_unlock_cause: assert property ((block_unlocked & ~$past(block_unlocked)) != 0 |->
    ($past(op_done) && !$past(op_fail)) || ($past(op_done, 2) && !$past(op_fail, 2)))
    else $error("unlock without erase");
  chk_user_area: assert property (!boot_mode [*2] |-> map_user_area)
    else $error("user area not mapped");
  cover property (inplace_submode);
  cover property (flash_low_power);
  cover property (|block_unlocked);
endmodule // flash_rewrite_mode_control_props
bind flash_rewrite_mode_control flash_rewrite_mode_control_props #(.BLOCKS(BLOCKS)) props (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_ack_o(wb_ack_o), .nmi_event(nmi_event), .wdt_event(wdt_event), .boot_mode(boot_mode),
  .op_done(op_done), .op_fail(op_fail), .inplace_submode(inplace_submode),
  .status_reg_readable(status_reg_readable), .lock_ignore(lock_ignore),
  .block_unlocked(block_unlocked), .flash_access_ok(flash_access_ok),
  .flash_low_power(flash_low_power), .map_user_area(map_user_area));

// *** dv/flash_rewrite_mode_control_tb.sv ***
`timescale 1ns/100ps
`include "flash_ctl_defs.vh"
module flash_rewrite_mode_control_tb;
  localparam [3:0] r0 = `ADR_CTL0, r1 = `ADR_CTL1;
  logic        clk_sys = 0, rst_n = 0, cyc = 0, we = 0, nmi = 0, boot = 1;
  logic        done = 0, fail = 0, lk = 0, wdt = 0, en = 1;
  logic [3:0]  adr = 0, blk = 0;
  logic [2:0]  opk = 0;
  logic [31:0] wdat = 0, rdat;
  wire  [31:0] dat_o;
  wire         ack, acc_c, inpl, srr, lig, acc, lowp, init, map;
  wire  [10:0] unl;
  integer      fail_count = 0, total_checks = 0, cycles = 0;
  flash_rewrite_mode_control #(.BLOCKS(11)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack), .nmi_event(nmi),
    .wdt_event(wdt), .boot_mode(boot), .op_start(opk), .op_block(blk), .op_done(done),
    .op_fail(fail), .op_lock_state(lk), .cmd_accept(acc_c), .inplace_submode(inpl),
    .status_reg_readable(srr), .lock_ignore(lig), .block_unlocked(unl),
    .flash_access_ok(acc), .flash_low_power(lowp), .flash_init(init),
    .map_user_area(map), .op_abort());
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  task conclude;
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // The request is held until ack is sampled high; read data is taken at that edge.
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
    we <= 0;
  endtask
  task rc(input logic [3:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h00_0000, e}, rdat);
  endtask
  task wt;
    repeat (3) @(posedge clk_sys);
  endtask
  task op(input logic [2:0] k, input logic [3:0] b);
    @(posedge clk_sys);
    opk <= k;
    blk <= b;
    @(posedge clk_sys);
    opk <= 0;
  endtask
  task fin(input logic f, input logic l);
    @(posedge clk_sys);
    done <= 1;
    fail <= f;
    lk <= l;
    @(posedge clk_sys);
    done <= 0;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    rc(r0, 8'h01);
    rc(r1, 8'h00);
    rc(4'h8, 8'h00);
    bus(1, r0, 8'h02);
    rc(r0, 8'h01);
    bus(1, r0, 8'h00);
    bus(1, r0, 8'h02);
    rc(r0, 8'h03);
    wt;
    chk("cmd_accept", 1, acc_c);
    chk("status_readable", 1, srr);
    bus(1, r1, 8'h02);
    rc(r1, 8'h00);
    bus(1, r1, 8'h00);
    bus(1, r1, 8'h02);
    rc(r1, 8'h02);
    wt;
    chk("status_readable", 0, srr);
    bus(1, r0, 8'hC3);
    rc(r0, 8'h03);
    op(`OP_PROGRAM, 0);
    rc(r0, 8'h02);
    fin(1, 0);
    rc(r0, 8'h43);
    op(`OP_ERASE, 1);
    fin(1, 0);
    rc(r0, 8'hC3);
    op(`OP_CLEAR, 0);
    rc(r0, 8'h03);
    bus(1, r0, 8'h03);
    bus(1, r0, 8'h07);
    wt;
    chk("lock_ignore", 1, lig);
    op(`OP_ERASE, 3);
    fin(0, 0);
    wt;
    chk("unlocked", 11'h008, unl);
    op(`OP_LOCK_READ, 3);
    fin(0, 1);
    rc(r1, 8'h42);
    bus(1, r0, 8'h03);
    wt;
    chk("lock_ignore", 0, lig);
    chk("unlocked", 11'h008, unl);
    bus(1, r0, 8'h00);
    rc(r1, 8'h40);
    bus(1, r0, 8'h08);
    rc(r0, 8'h09);
    chk("low_power", 0, lowp);
    bus(1, r0, 8'h0A);
    wt;
    chk("low_power", 1, lowp);
    chk("access", 0, acc);
    chk("init", 1, init);
    @(posedge clk_sys);
    nmi <= 1;
    @(posedge clk_sys);
    nmi <= 0;
    rc(r0, 8'h01);
    rc(r1, 8'h00);
    chk("user_area", 0, map);
    bus(1, r0, 8'h20);
    wt;
    chk("user_area", 1, map);
    // A reinit pulse while the clock enable is low must leave all state alone.
    @(posedge clk_sys);
    en <= 0;
    nmi <= 1;
    @(posedge clk_sys);
    nmi <= 0;
    en <= 1;
    wt;
    chk("frozen_area", 1, map);
    @(posedge clk_sys);
    wdt <= 1;
    @(posedge clk_sys);
    wdt <= 0;
    wt;
    chk("user_area", 0, map);
    boot <= 0;
    wt;
    chk("user_area", 1, map);
    conclude;
  end
endmodule // flash_rewrite_mode_control_tb
